//--- core/wwd_pkg.sv
package wwd_pkg;

    // register byte offsets
    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_INT_STAT = 8'h04;
    localparam logic [7:0] REG_INT_MASK = 8'h08;
    localparam logic [7:0] REG_CAP_RST  = 8'h0c;
    localparam logic [7:0] REG_CAP_WDU  = 8'h10;

    // status register fields
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_EN_BIT    = 1;
    localparam int ST_SEL_LSB   = 2;
    localparam int ST_RCLS_LSB  = 4;
    localparam int ST_WCLS_LSB  = 6;
    localparam int ST_STATE_LSB = 8;

    // interrupt status / mask fields
    localparam int IRQ_W       = 3;
    localparam int IRQ_FAULT   = 0;
    localparam int IRQ_EARLY   = 1;
    localparam int IRQ_LATE    = 2;

    // reset values of the capacitor timing registers, in microseconds
    localparam logic [31:0] CAP_RST_RESET = 32'h0000_2710;
    localparam logic [31:0] CAP_WDU_RESET = 32'h0000_c350;

    // timebase
    localparam int CLK_NS  = 5;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    // times in microseconds
    localparam logic [31:0] PIN_CLASSIFY_US = 32'd381;
    localparam logic [31:0] ENABLE_SETTLE_US = 32'd150;
    localparam logic [31:0] RST_OPEN_US     = 32'd200000;
    localparam logic [31:0] RST_PULL_US     = 32'd10000;
    localparam logic [31:0] WDL_OPEN_00_US  = 32'd22500;
    localparam logic [31:0] WDL_OPEN_10_US  = 32'd1850;
    localparam logic [31:0] WDL_OPEN_11_US  = 32'd800000;
    localparam logic [31:0] WDU_OPEN_00_US  = 32'd55000;
    localparam logic [31:0] WDU_OPEN_10_US  = 32'd27500;
    localparam logic [31:0] WDU_OPEN_11_US  = 32'd1600000;
    localparam logic [31:0] WDL_PULL_00_US  = 32'd9000;
    localparam logic [31:0] WDL_PULL_10_US  = 32'd9000;
    localparam logic [31:0] WDL_PULL_11_US  = 32'd1850;
    localparam logic [31:0] WDU_PULL_00_US  = 32'd109000;
    localparam logic [31:0] WDU_PULL_10_US  = 32'd195000;
    localparam logic [31:0] WDU_PULL_11_US  = 32'd11000;

    // select code is {ratio_select_bit1, ratio_select_bit0}
    localparam logic [1:0] SEL_R18 = 2'b00;
    localparam logic [1:0] SEL_OFF = 2'b01;
    localparam logic [1:0] SEL_R34 = 2'b10;
    localparam logic [1:0] SEL_R12 = 2'b11;

    typedef enum logic [1:0] {
        CLS_OPEN = 2'b00,
        CLS_PULL = 2'b01,
        CLS_CAP  = 2'b10
    } wwd_cls_e;

    typedef enum logic [7:0] {
        S_OFF    = 8'h01,
        S_INIT   = 8'h02,
        S_PWRUP  = 8'h04,
        S_DIS    = 8'h08,
        S_SETTLE = 8'h10,
        S_FIRST  = 8'h20,
        S_WIN    = 8'h40,
        S_FAULT  = 8'h80
    } wwd_state_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } wwd_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } wwd_apb_rsp_s;

    typedef struct packed {
        wwd_state_e       st;
        logic [31:0]      cnt;
        logic [15:0]      div;
        logic             kick_prev;
        logic [1:0]       sel;
        logic [1:0]       rst_cls;
        logic [1:0]       win_cls;
        logic             fault_abort;
        logic             fault_n;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0]      cap_rst;
        logic [31:0]      cap_wdu;
        logic [31:0]      prdata;
        logic             pslverr;
    } wwd_state_s;

endpackage : wwd_pkg

//--- core/wwd_top.sv
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
// How it works
// - at power-up classify the reset-delay pin during a 381 us sequence
// - at supply rise classify the window-timing pin in the same 381 us
// - enable or disable by the select pins acts immediately
// - while enabled a new ratio latches only at a fault or undervoltage
// - after enabling, kicks are ignored for 150 us
// - select bit0=1, bit1=0 disables; with a timing capacitor other codes give 1:8, 3:4, 1:2
// - with a timing capacitor 00 gives 1/8, 11 gives 1/2, bit0=0 bit1=1 gives 3/4
// - while disabled fault output stays high and kicks are ignored
// - only a falling kick edge counts
// - first kick after enable or fault checks only the upper bound
// - interval below lower or above upper bound asserts fault low
// - fault holds low a full reset delay, kicks ignored, then resumes
// - factory delay: disable/re-enable in fault acts as plain enable
// - capacitor delay: disable releases at once, re-enable runs delay
// - with supply below operating level stay disabled, output high
// - at power-up stay disabled for one reset delay first
module wwd_top #(
    parameter int TICK_CYC = wwd_pkg::TICK_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire wwd_pkg::wwd_apb_req_s apb_req,
    output wwd_pkg::wwd_apb_rsp_s      apb_rsp,
    input  wire logic                  supply_ok,
    input  wire logic [1:0]            reset_delay_cfg_pin,
    input  wire logic [1:0]            window_timing_cfg_pin,
    input  wire logic                  ratio_select_bit0,
    input  wire logic                  ratio_select_bit1,
    input  wire logic                  kick_input,
    output logic                       fault_output_n,
    output logic                       irq
);

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    localparam int          IRQ_W_L   = wwd_pkg::IRQ_W;

    wwd_pkg::wwd_state_s s_q;
    wwd_pkg::wwd_state_s s_d;

    logic             tick;
    logic             fall;
    logic [1:0]       live;
    logic             live_off;
    logic             enabled;
    logic [31:0]      rst_us;
    logic [31:0]      up_us;
    logic [31:0]      lo_us;
    logic [IRQ_W_L-1:0] ev;
    logic             setup;
    logic             wr;
    logic             mapped;
    logic [IRQ_W_L-1:0] w1c;

    // upper bound for the latched ratio and window-timing class
    function automatic logic [31:0] upper_of(input logic [1:0] cls,
                                             input logic [1:0] sel,
                                             input logic [31:0] cap);
        logic [31:0] r;
        r = cap;
        if (cls == wwd_pkg::CLS_OPEN) begin
            unique case (sel)
                wwd_pkg::SEL_R18: r = wwd_pkg::WDU_OPEN_00_US;
                wwd_pkg::SEL_R34: r = wwd_pkg::WDU_OPEN_10_US;
                default:          r = wwd_pkg::WDU_OPEN_11_US;
            endcase
        end else if (cls == wwd_pkg::CLS_PULL) begin
            unique case (sel)
                wwd_pkg::SEL_R18: r = wwd_pkg::WDU_PULL_00_US;
                wwd_pkg::SEL_R34: r = wwd_pkg::WDU_PULL_10_US;
                default:          r = wwd_pkg::WDU_PULL_11_US;
            endcase
        end
        return r;
    endfunction : upper_of

    // lower bound; with a timing capacitor it is the ratio of the upper
    function automatic logic [31:0] lower_of(input logic [1:0] cls,
                                             input logic [1:0] sel,
                                             input logic [31:0] up);
        logic [31:0] r;
        r = up >> 1;
        if (cls == wwd_pkg::CLS_OPEN) begin
            unique case (sel)
                wwd_pkg::SEL_R18: r = wwd_pkg::WDL_OPEN_00_US;
                wwd_pkg::SEL_R34: r = wwd_pkg::WDL_OPEN_10_US;
                default:          r = wwd_pkg::WDL_OPEN_11_US;
            endcase
        end else if (cls == wwd_pkg::CLS_PULL) begin
            unique case (sel)
                wwd_pkg::SEL_R18: r = wwd_pkg::WDL_PULL_00_US;
                wwd_pkg::SEL_R34: r = wwd_pkg::WDL_PULL_10_US;
                default:          r = wwd_pkg::WDL_PULL_11_US;
            endcase
        end else begin
            unique case (sel)
                wwd_pkg::SEL_R18: r = up >> 3;
                wwd_pkg::SEL_R34: r = up - (up >> 2);
                default:          r = up >> 1;
            endcase
        end
        return r;
    endfunction : lower_of

    always_comb begin
        s_d      = s_q;
        ev       = '0;
        tick     = (s_q.div == TICK_LAST);
        fall     = s_q.kick_prev & ~kick_input;
        live     = {ratio_select_bit1, ratio_select_bit0};
        live_off = (live == wwd_pkg::SEL_OFF);
        enabled  = (s_q.st == wwd_pkg::S_SETTLE) ||
                   (s_q.st == wwd_pkg::S_FIRST) ||
                   (s_q.st == wwd_pkg::S_WIN) ||
                   (s_q.st == wwd_pkg::S_FAULT);
        if (s_q.rst_cls == wwd_pkg::CLS_CAP) begin
            rst_us = s_q.cap_rst;
        end else if (s_q.rst_cls == wwd_pkg::CLS_PULL) begin
            rst_us = wwd_pkg::RST_PULL_US;
        end else begin
            rst_us = wwd_pkg::RST_OPEN_US;
        end
        up_us = upper_of(s_q.win_cls, s_q.sel, s_q.cap_wdu);
        lo_us = lower_of(s_q.win_cls, s_q.sel, up_us);

        // microsecond timebase shared by every delay
        s_d.div       = tick ? 16'h0000 : s_q.div + 16'h0001;
        s_d.kick_prev = kick_input;
        if (tick) begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end

        unique case (s_q.st)
            wwd_pkg::S_OFF: begin
                s_d.fault_n = 1'b1;
                if (supply_ok) begin
                    s_d.st  = wwd_pkg::S_INIT;
                    s_d.cnt = '0;
                end
            end
            wwd_pkg::S_INIT: begin
                if (s_q.cnt >= wwd_pkg::PIN_CLASSIFY_US) begin
                    s_d.rst_cls = reset_delay_cfg_pin;
                    s_d.win_cls = window_timing_cfg_pin;
                    s_d.sel     = live;
                    s_d.st      = wwd_pkg::S_PWRUP;
                    s_d.cnt     = '0;
                end
            end
            wwd_pkg::S_PWRUP: begin
                if (s_q.cnt >= rst_us) begin
                    s_d.sel = live;
                    s_d.cnt = '0;
                    s_d.st  = live_off ? wwd_pkg::S_DIS : wwd_pkg::S_SETTLE;
                end
            end
            wwd_pkg::S_DIS: begin
                s_d.fault_n = 1'b1;
                if (!live_off) begin
                    s_d.sel         = live;
                    s_d.cnt         = '0;
                    s_d.fault_abort = 1'b0;
                    if (s_q.fault_abort &&
                        s_q.rst_cls == wwd_pkg::CLS_CAP) begin
                        s_d.st      = wwd_pkg::S_FAULT;
                        s_d.fault_n = 1'b0;
                    end else begin
                        s_d.st = wwd_pkg::S_SETTLE;
                    end
                end
            end
            wwd_pkg::S_SETTLE: begin
                if (s_q.cnt >= wwd_pkg::ENABLE_SETTLE_US) begin
                    s_d.st  = wwd_pkg::S_FIRST;
                    s_d.cnt = '0;
                end
            end
            wwd_pkg::S_FIRST: begin
                if (fall) begin
                    s_d.st  = wwd_pkg::S_WIN;
                    s_d.cnt = '0;
                end else if (s_q.cnt > up_us) begin
                    ev[wwd_pkg::IRQ_LATE] = 1'b1;
                end
            end
            wwd_pkg::S_WIN: begin
                if (fall && s_q.cnt < lo_us) begin
                    ev[wwd_pkg::IRQ_EARLY] = 1'b1;
                end else if (fall) begin
                    s_d.cnt = '0;
                end else if (s_q.cnt > up_us) begin
                    ev[wwd_pkg::IRQ_LATE] = 1'b1;
                end
            end
            wwd_pkg::S_FAULT: begin
                // kicks ignored until the delay runs out
                if (s_q.cnt >= rst_us) begin
                    s_d.st      = wwd_pkg::S_FIRST;
                    s_d.cnt     = '0;
                    s_d.fault_n = 1'b1;
                end
            end
        endcase

        if (ev[wwd_pkg::IRQ_EARLY] || ev[wwd_pkg::IRQ_LATE]) begin
            ev[wwd_pkg::IRQ_FAULT] = 1'b1;
            s_d.st      = wwd_pkg::S_FAULT;
            s_d.cnt     = '0;
            s_d.fault_n = 1'b0;
            s_d.sel     = live;
        end

        // disable overrides everything but undervoltage, even a running fault delay
        if (enabled && live_off) begin
            s_d.st          = wwd_pkg::S_DIS;
            s_d.fault_n     = 1'b1;
            s_d.fault_abort = (s_q.st == wwd_pkg::S_FAULT);
            ev              = '0;
        end
        if (!supply_ok) begin
            s_d.st          = wwd_pkg::S_OFF;
            s_d.fault_n     = 1'b1;
            s_d.fault_abort = 1'b0;
            ev              = '0;
        end

        // apb slave: decode in setup, commit at the access edge
        setup  = apb_req.psel & ~apb_req.penable;
        wr     = apb_req.psel & apb_req.penable & apb_req.pwrite;
        mapped = (apb_req.paddr == wwd_pkg::REG_STATUS) ||
                 (apb_req.paddr == wwd_pkg::REG_INT_STAT) ||
                 (apb_req.paddr == wwd_pkg::REG_INT_MASK) ||
                 (apb_req.paddr == wwd_pkg::REG_CAP_RST) ||
                 (apb_req.paddr == wwd_pkg::REG_CAP_WDU);
        w1c = '0;
        if (wr) begin
            unique case (apb_req.paddr)
                wwd_pkg::REG_INT_STAT: w1c = apb_req.pwdata[IRQ_W_L-1:0];
                wwd_pkg::REG_INT_MASK:
                    s_d.irq_mask = apb_req.pwdata[IRQ_W_L-1:0];
                wwd_pkg::REG_CAP_RST: s_d.cap_rst = apb_req.pwdata;
                wwd_pkg::REG_CAP_WDU: s_d.cap_wdu = apb_req.pwdata;
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
        if (setup) begin
            s_d.pslverr = ~mapped;
            s_d.prdata  = '0;
            if (!apb_req.pwrite) begin
                unique case (apb_req.paddr)
                    wwd_pkg::REG_STATUS: begin
                        s_d.prdata[wwd_pkg::ST_FAULT_BIT] = ~s_q.fault_n;
                        s_d.prdata[wwd_pkg::ST_EN_BIT]    = enabled;
                        s_d.prdata[wwd_pkg::ST_SEL_LSB +: 2]  = s_q.sel;
                        s_d.prdata[wwd_pkg::ST_RCLS_LSB +: 2] = s_q.rst_cls;
                        s_d.prdata[wwd_pkg::ST_WCLS_LSB +: 2] = s_q.win_cls;
                        s_d.prdata[wwd_pkg::ST_STATE_LSB +: 8] = s_q.st;
                    end
                    wwd_pkg::REG_INT_STAT:
                        s_d.prdata[IRQ_W_L-1:0] = s_q.irq_stat;
                    wwd_pkg::REG_INT_MASK:
                        s_d.prdata[IRQ_W_L-1:0] = s_q.irq_mask;
                    wwd_pkg::REG_CAP_RST: s_d.prdata = s_q.cap_rst;
                    wwd_pkg::REG_CAP_WDU: s_d.prdata = s_q.cap_wdu;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.st          <= wwd_pkg::S_OFF;
            s_q.cnt         <= '0;
            s_q.div         <= '0;
            s_q.kick_prev   <= 1'b0;
            s_q.sel         <= wwd_pkg::SEL_OFF;
            s_q.rst_cls     <= wwd_pkg::CLS_OPEN;
            s_q.win_cls     <= wwd_pkg::CLS_OPEN;
            s_q.fault_abort <= 1'b0;
            s_q.fault_n     <= 1'b1;
            s_q.irq_stat    <= '0;
            s_q.irq_mask    <= '0;
            s_q.cap_rst     <= wwd_pkg::CAP_RST_RESET;
            s_q.cap_wdu     <= wwd_pkg::CAP_WDU_RESET;
            s_q.prdata      <= '0;
            s_q.pslverr     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // zero wait states: the access phase always completes at once
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.prdata  = s_q.prdata;
    assign apb_rsp.pslverr = s_q.pslverr;
    assign fault_output_n  = s_q.fault_n;
    assign irq             = |(s_q.irq_stat & s_q.irq_mask);

endmodule : wwd_top

//--- sim/wwd_chk.sv
`timescale 1ns/1ps
module wwd_chk #(
    parameter int TICK_CYC = 200
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire wwd_pkg::wwd_apb_req_s apb_req,
    input wire wwd_pkg::wwd_apb_rsp_s apb_rsp,
    input wire logic                  supply_ok,
    input wire logic                  ratio_select_bit0,
    input wire logic                  ratio_select_bit1,
    input wire logic                  fault_output_n,
    input wire logic                  irq
);
    // no fault before classify plus enable settling can have run
    localparam int QUIET_CYC = (381 + 150) * TICK_CYC;
    logic        dis;
    logic [31:0] up_q;
    logic [31:0] up_d;
    assign dis  = ratio_select_bit0 && !ratio_select_bit1;
    assign up_d = supply_ok ? up_q + {31'h0, ~&up_q} : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 32'h0;
        end else begin
            up_q <= up_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_dis_quiet: assert property (dis [*4] |-> fault_output_n)
        else $error("fault low while disabled");
    chk_uv_quiet: assert property (!supply_ok [*3] |-> fault_output_n)
        else $error("fault low without supply");
    chk_dis_release: assert property (
        $rose(dis) |-> ##[0:2] fault_output_n)
        else $error("disable did not release fault");
    chk_fault_hold: assert property ($fell(fault_output_n) |->
        (!fault_output_n || dis || !supply_ok) [*8])
        else $error("fault pulse too short");
    chk_init_quiet: assert property (
        up_q < QUIET_CYC |-> fault_output_n)
        else $error("fault during power-up");
    chk_fall_cause: assert property ($fell(fault_output_n) |->
        $past(supply_ok) && !$past(dis))
        else $error("fault while not monitoring");
    chk_first_free: assert property (
        $rose(fault_output_n) && !dis |-> fault_output_n [*3])
        else $error("fault right after release");
    chk_unmapped: assert property (apb_req.psel && apb_req.penable &&
        apb_req.paddr > 8'h10 |-> apb_rsp.pslverr)
        else $error("unmapped access without error");
    cover property ($fell(fault_output_n));
    cover property ($rose(dis) && !fault_output_n);
    cover property ($rose(irq));
endmodule : wwd_chk

bind wwd_top wwd_chk #(.TICK_CYC(TICK_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .supply_ok(supply_ok), .ratio_select_bit0(ratio_select_bit0),
    .ratio_select_bit1(ratio_select_bit1),
    .fault_output_n(fault_output_n), .irq(irq));

//--- sim/wwd_host_model.sv
`timescale 1ns/1ps
module wwd_host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic [31:0] gap,
    input  wire logic        fault_output_n,
    output logic             kick_input
);
    logic [31:0] cnt_q;
    // a fault resets the processor, so its kick schedule restarts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q      <= 32'h0;
            kick_input <= 1'b1;
        end else if (!fault_output_n || !run) begin
            cnt_q      <= 32'h0;
            kick_input <= 1'b1;
        end else if (cnt_q + 32'h1 >= gap) begin
            cnt_q      <= 32'h0;
            kick_input <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            // low for 12 cycles, above the minimum pulse width
            if (cnt_q == 32'hb) kick_input <= 1'b1;
        end
    end
endmodule : wwd_host_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int TK = 2;
    logic                  pclk, presetn, supply_ok, sel0, sel1, run;
    logic                  kick, fault_n, fault_s, irq, err;
    logic [1:0]            cfg;
    logic [31:0]           gap, q, seed;
    wwd_pkg::wwd_apb_req_s req;
    wwd_pkg::wwd_apb_rsp_s rsp;
    int                    n_errors, n_compared, c;
    logic [1:0]            sel_t [3] = '{2'b00, 2'b10, 2'b11};
    int                    low_t [3] = '{50, 300, 200};
    // both pins share one class: capacitor first, then pulled up
    wwd_top #(.TICK_CYC(TK)) dut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .supply_ok(supply_ok), .reset_delay_cfg_pin(cfg),
        .window_timing_cfg_pin(cfg), .ratio_select_bit0(sel0),
        .ratio_select_bit1(sel1), .kick_input(kick),
        .fault_output_n(fault_n), .irq(irq));
    wwd_host_model host (
        .pclk(pclk), .presetn(presetn), .run(run), .gap(gap),
        .fault_output_n(fault_n), .kick_input(kick));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rng(input string n, input int lo, input int hi, int g);
        n_compared++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("unexpected %s: expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : rng
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
    endtask : apb
    task automatic rd_chk(input string n, input logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rd_chk
    task automatic st(input string n, input logic [31:0] m, logic [31:0] e);
        apb(1'b0, wwd_pkg::REG_STATUS, 32'h0);
        chk(n, e, q & m);
    endtask : st
    // bounded wait for the fault output to reach a level; c holds cycles
    task automatic wlvl(input logic v, input int lim);
        c = 0;
        while (fault_s !== v && c < lim) begin
            @(posedge pclk);
            c++;
        end
    endtask : wlvl
    task automatic stop_test();
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // settled copy, so no race with the edge that launches the output
    always @(negedge pclk) fault_s <= fault_n;
    initial begin
        repeat (80000) @(posedge pclk);
        n_errors++;
        stop_test();
    end
    initial begin
        {presetn, supply_ok, sel0, sel1, run} = 5'h0;
        gap = 32'h100;
        req = '0;
        cfg = 2'b10;
        seed = 32'hbbc997d9;
        n_errors = 0;
        n_compared = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("cap_rst", wwd_pkg::REG_CAP_RST, wwd_pkg::CAP_RST_RESET);
        rd_chk("cap_wdu", wwd_pkg::REG_CAP_WDU, wwd_pkg::CAP_WDU_RESET);
        rd_chk("int_mask", wwd_pkg::REG_INT_MASK, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        gap = rnd() & 32'h7;
        apb(1'b1, wwd_pkg::REG_INT_MASK, gap);
        rd_chk("int_mask", wwd_pkg::REG_INT_MASK, gap);
        apb(1'b1, wwd_pkg::REG_INT_MASK, 32'h7);
        apb(1'b1, wwd_pkg::REG_CAP_RST, 32'd40);
        apb(1'b1, wwd_pkg::REG_CAP_WDU, 32'd400);
        chk("fault off", 32'h1, {31'h0, fault_n});
        supply_ok <= 1'b1;
        run <= 1'b1;
        gap <= TK * 200;
        repeat (TK * 370) @(posedge pclk);
        st("classify", 32'hff00, 32'h0200);
        repeat (TK * 20) @(posedge pclk);
        st("powerup", 32'hffff, 32'h04a0);
        wlvl(1'b0, TK * 700);
        chk("settle", TK * 700, c);
        st("window", 32'hffff, 32'h40a2);
        for (int k = 0; k < 3; k++) begin
            if (k == 1) sel1 <= 1'b1;
            if (k == 2) sel0 <= 1'b1;
            if (k > 0) st("sel hold", 32'hc, {28'h0, sel_t[k-1], 2'b0});
            gap <= TK * 42;
            wlvl(1'b0, TK * 1000);
            rng("early", 1, TK * 1000 - 1, c);
            gap <= TK * (low_t[k] + 8 + rnd() % (384 - low_t[k]));
            wlvl(1'b1, TK * 100);
            rng("fault len", TK * 39, TK * 42, c);
            st("sel latch", 32'hc, {28'h0, sel_t[k], 2'b0});
            if (k == 0) begin
                chk("irq", 32'h1, {31'h0, irq});
                rd_chk("int_stat", wwd_pkg::REG_INT_STAT, 32'h3);
                apb(1'b1, wwd_pkg::REG_INT_MASK, 32'h0);
                chk("irq masked", 32'h0, {31'h0, irq});
                apb(1'b1, wwd_pkg::REG_INT_STAT, 32'h7);
                rd_chk("int_stat", wwd_pkg::REG_INT_STAT, 32'h0);
                apb(1'b1, wwd_pkg::REG_INT_MASK, 32'h7);
            end
            wlvl(1'b0, TK * 1200);
            chk("in window", TK * 1200, c);
            gap <= TK * (low_t[k] - 8);
            wlvl(1'b0, TK * 1000);
            rng("tight", 1, TK * 1000 - 1, c);
            wlvl(1'b1, TK * 100);
            run <= 1'b0;
            wlvl(1'b0, TK * 500);
            rng("late", TK * 398, TK * 404, c);
            wlvl(1'b1, TK * 100);
            run <= 1'b1;
            gap <= TK * 200;
        end
        @(posedge pclk);
        gap <= TK * 42;
        wlvl(1'b0, TK * 1000);
        repeat (TK * 5) @(posedge pclk);
        sel1 <= 1'b0;
        wlvl(1'b1, 4);
        rng("release", 0, 3, c);
        wlvl(1'b0, TK * 600);
        chk("disabled", TK * 600, c);
        st("dis state", 32'hff00, 32'h0800);
        run <= 1'b0;
        sel1 <= 1'b1;
        wlvl(1'b0, 8);
        rng("re-arm", 0, 7, c);
        wlvl(1'b1, TK * 100);
        rng("re-arm len", TK * 39, TK * 42, c);
        // second supply cycle with pulled-up pins: factory timing
        run <= 1'b1;
        supply_ok <= 1'b0;
        cfg <= 2'b01;
        repeat (TK * 5) @(posedge pclk);
        st("uv off", 32'hff01, 32'h0100);
        supply_ok <= 1'b1;
        wlvl(1'b0, TK * 10700);
        rng("pull early", TK * 10531, TK * 10700 - 1, c);
        st("pull cls", 32'h00f0, 32'h0050);
        sel1 <= 1'b0;
        wlvl(1'b1, 4);
        rng("pull release", 0, 3, c);
        repeat (TK * 5) @(posedge pclk);
        sel1 <= 1'b1;
        wlvl(1'b0, TK * 300);
        rng("pull enable", TK * 150, TK * 300 - 1, c);
        stop_test();
    end
endmodule : tb_top
